/* design/dtfs_axil_slave.sv */
// AXI4-Lite slave holding the control register and presenting status
// assumes one write and one read in flight at most; answers one cycle after both halves
`timescale 1ns/1ps
module dtfs_axil_slave (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [dtfs_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [dtfs_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire dtfs_pkg::dtfs_stat_t stat,
  output dtfs_pkg::dtfs_ctrl_t ctrl
);
  import dtfs_pkg::*;
  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wstrb0_ff;
  dtfs_ctrl_t ctrl_ff;

  logic nxt_aw_got;
  logic nxt_w_got;
  logic nxt_bvalid;
  logic nxt_rvalid;

  assign ctrl = ctrl_ff;

  // readies are registered from the next state so every port is a flop output
  always_comb begin
    nxt_aw_got = aw_got_ff || (s_awvalid && s_awready);
    nxt_w_got = w_got_ff || (s_wvalid && s_wready);
    nxt_bvalid = s_bvalid;
    if (aw_got_ff && w_got_ff && !s_bvalid) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
    end else if (s_bvalid && s_bready) begin
      nxt_bvalid = 1'b0;
    end
    nxt_rvalid = s_rvalid;
    if (s_arvalid && s_arready) begin
      nxt_rvalid = 1'b1;
    end else if (s_rvalid && s_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_arready <= 1'b0;
    end else begin
      s_awready <= !nxt_aw_got && !nxt_bvalid;
      s_wready <= !nxt_w_got && !nxt_bvalid;
      s_arready <= !nxt_rvalid;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb0_ff <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
      ctrl_ff <= CTRL_RESET_VAL;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_wdata;
        wstrb0_ff <= s_wstrb[0];
      end
      if (aw_got_ff && w_got_ff && !s_bvalid) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_bvalid <= 1'b1;
        if (awaddr_ff == CTRL_OFS) begin
          s_bresp <= 2'h0;
          if (wstrb0_ff) begin
            ctrl_ff <= wdata_ff[2:0];
          end
        end else if (awaddr_ff == STAT_OFS) begin
          s_bresp <= 2'h0;
        end else begin
          s_bresp <= 2'h2;
        end
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= 2'h0;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      if (s_araddr == CTRL_OFS) begin
        s_rdata <= {29'h0, ctrl_ff};
        s_rresp <= 2'h0;
      end else if (s_araddr == STAT_OFS) begin
        s_rdata <= {27'h0, stat};
        s_rresp <= 2'h0;
      end else begin
        s_rdata <= 32'h0;
        s_rresp <= 2'h2;
      end
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule // dtfs_axil_slave

/* design/dtfs_delay_line.sv */
// parameterised shift-register delay line, one stage per enabled step
// assumes a synchronous enable pulse and an active-low async reset
`timescale 1ns/1ps
module dtfs_delay_line #(
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic step,
  input wire logic din,
  output logic dout
);
  import dtfs_pkg::*;
  logic [DEPTH-1:0] stage_ff;

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_stage
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          stage_ff[gi] <= 1'b0;
        end else if (step) begin
          stage_ff[gi] <= (gi == 0) ? din : stage_ff[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate

  assign dout = stage_ff[DEPTH-1];
endmodule // dtfs_delay_line

/* design/dtfs_pkg.sv */
// package for the disk track formatter sequencer: register map, field positions, timing counts
// assumes an AXI4-Lite master with 32-bit data on the register side
package dtfs_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  // control fields
  localparam int unsigned CTRL_FRST_BIT = 0;
  localparam int unsigned CTRL_WRITE_BIT = 1;
  localparam int unsigned CTRL_SHIFT_BIT = 2;
  localparam logic [2:0] CTRL_RESET_VAL = 3'h0;
  // status fields
  localparam int unsigned STAT_CHECK_BIT = 0;
  localparam int unsigned STAT_HIT_BIT = 1;
  localparam int unsigned STAT_RATE_BIT = 2;
  localparam int unsigned STAT_CRCEN_BIT = 3;
  localparam int unsigned STAT_SHIFT_BIT = 4;
  // sync pattern and mark second halves
  localparam logic [7:0] SYNC_PATTERN = 8'hF5;
  localparam logic [7:0] ID_MARK_TAIL = 8'h7E;
  localparam logic [7:0] DATA_MARK_TAIL = 8'h6F;
  // timing
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned REF_CLK_HZ = 500_000;
  localparam int unsigned REF_DIV = SYS_CLK_HZ / REF_CLK_HZ;
  localparam int unsigned SHIFT_DELAY_NS = 1000;
  localparam int unsigned SHIFT_DELAY_CYC = (SHIFT_DELAY_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned READ_CLK_DLY = 4;
  localparam int unsigned CRC_LAG_BITS = 8;
  localparam int unsigned GAP_UNDERFLOWS = 11;

  typedef struct packed {
    logic shift_cmd;
    logic write_mode;
    logic formatter_reset;
  } dtfs_ctrl_t;

  typedef struct packed {
    logic shift_active;
    logic crc_enable;
    logic rate_fast;
    logic hit;
    logic check_result;
  } dtfs_stat_t;
endpackage

/* design/dtfs_sequencer.sv */
// top of the disk track formatter sequencer: read and write clock-rate sequencing,
// check generator gating and check-result latch, with an AXI4-Lite register port
// assumes all link inputs are synchronous to clk_sys; ref_clk is a sampled 500 kHz level
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module dtfs_sequencer #(
  parameter int unsigned SHIFT_DLY_CYC = dtfs_pkg::SHIFT_DELAY_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [dtfs_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [dtfs_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic ref_clk,
  input wire logic read_data,
  input wire logic pattern_hit_pulse,
  input wire logic tx_underflow,
  input wire logic check_all_zero_n,
  output logic adapter_rx_clk,
  output logic adapter_tx_clk,
  output logic check_gen_clk,
  output logic check_gen_data,
  output logic check_gen_enable,
  output logic check_gen_preset,
  output logic check_gen_shift,
  output logic check_result
);
  import dtfs_pkg::*;

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic frst_n;
  dtfs_ctrl_t ctrl;
  dtfs_stat_t stat;
  logic ref_d_ff;
  logic ref_rise;
  logic ref_fall;
  logic [READ_CLK_DLY-1:0] rdclk_dly_ff;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic hit_ff;
  logic rate_fast_ff;
  logic crc_en_ff;
  logic q3_prev_ff;
  logic q3_rise;
  logic q3n_rise;
  logic check_ff;
  logic shift_req_ff;
  logic [$clog2(SHIFT_DLY_CYC + 1)-1:0] shift_cnt_ff;
  logic shift_out_ff;
  logic crc_data_dly;
  logic frst_prev_ff;

  // system reset release through two flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  dtfs_axil_slave u_regs (
    .clk_sys(clk_sys),
    .rst_n(rst_sync_ff),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .stat(stat),
    .ctrl(ctrl)
  );

  // formatter reset is a software level; while high it holds the bit counter, latches and shift delay at their reset values
  assign frst_n = rst_sync_ff && !ctrl.formatter_reset;

  assign stat.check_result = check_ff;
  assign stat.hit = hit_ff;
  assign stat.rate_fast = rate_fast_ff;
  assign stat.crc_enable = crc_en_ff;
  assign stat.shift_active = shift_out_ff;

  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ref_d_ff <= 1'b0;
    end else begin
      ref_d_ff <= ref_clk;
    end
  end

  assign ref_rise = ref_clk && !ref_d_ff;
  assign ref_fall = !ref_clk && ref_d_ff;

  // inverted read clock delayed a few system clocks so the rate select settles first
  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rdclk_dly_ff <= '0;
    end else begin
      rdclk_dly_ff <= {rdclk_dly_ff[READ_CLK_DLY-2:0], !ref_clk};
    end
  end

  // bit counter: read side runs while hit; write side reset by underflow only at 2X,
  // so a 1X underflow after the check bytes survives to the enable flop
  always_comb begin
    nxt_cnt = cnt_ff;
    if (ctrl.write_mode) begin
      if (tx_underflow && rate_fast_ff) begin
        nxt_cnt = 4'h0;
      end else if (ref_fall) begin
        nxt_cnt = cnt_ff + 4'h1;
      end
    end else if (hit_ff && ref_rise) begin
      nxt_cnt = cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge frst_n) begin
    if (!frst_n) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge clk_sys or negedge frst_n) begin
    if (!frst_n) begin
      q3_prev_ff <= 1'b0;
    end else begin
      q3_prev_ff <= cnt_ff[3];
    end
  end

  assign q3_rise = cnt_ff[3] && !q3_prev_ff;
  assign q3n_rise = !cnt_ff[3] && q3_prev_ff;

  // hit latch, cleared by formatter reset
  always_ff @(posedge clk_sys or negedge frst_n) begin
    if (!frst_n) begin
      hit_ff <= 1'b0;
    end else if (!ctrl.write_mode && ref_rise && pattern_hit_pulse) begin
      hit_ff <= 1'b1;
    end
  end

  // write enable flop: only set when counter bit 3 rises with no underflow
  always_ff @(posedge clk_sys or negedge frst_n) begin
    if (!frst_n) begin
      crc_en_ff <= 1'b0;
    end else if (ctrl.write_mode && q3_rise) begin
      crc_en_ff <= !tx_underflow;
    end
  end

  // rate latch: set on formatter reset, cleared once the mark has passed
  always_ff @(posedge clk_sys or negedge frst_n) begin
    if (!frst_n) begin
      rate_fast_ff <= 1'b1;
    end else if (ctrl.write_mode) begin
      if (q3_rise && crc_en_ff) begin
        rate_fast_ff <= 1'b0;
      end else if (q3_rise && !crc_en_ff && !rate_fast_ff) begin
        rate_fast_ff <= 1'b1;
      end
    end else if (hit_ff && q3_rise) begin
      rate_fast_ff <= 1'b0;
    end
  end

  // clock selectors and generator drive, all registered
  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      adapter_rx_clk <= 1'b0;
      adapter_tx_clk <= 1'b0;
      check_gen_clk <= 1'b0;
      check_gen_enable <= 1'b0;
      check_gen_preset <= 1'b1;
      check_gen_data <= 1'b0;
    end else begin
      adapter_rx_clk <= rate_fast_ff ? rdclk_dly_ff[READ_CLK_DLY-1] : cnt_ff[0];
      adapter_tx_clk <= rate_fast_ff ? ref_clk : cnt_ff[0];
      check_gen_clk <= !cnt_ff[0];
      check_gen_enable <= ctrl.write_mode ? crc_en_ff : hit_ff;
      check_gen_preset <= !frst_n;
      check_gen_data <= crc_data_dly;
    end
  end

  // eight-bit lag on the check path so the mark's first half is counted
  dtfs_delay_line #(
    .DEPTH(CRC_LAG_BITS)
  ) u_crc_lag (
    .clk_sys(clk_sys),
    .rst_n(rst_sync_ff),
    .step(ref_rise),
    .din(read_data),
    .dout(crc_data_dly)
  );

  // check-result latch: cleared on inverted bit 3 rise when zero flag low, else reclocked high
  always_ff @(posedge clk_sys or negedge frst_n) begin
    if (!frst_n) begin
      check_ff <= 1'b1;
    end else if (hit_ff && q3n_rise) begin
      check_ff <= check_all_zero_n;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      check_result <= 1'b1;
    end else begin
      check_result <= check_ff;
    end
  end

  // shift command: sampled at bit 3 rise, then held off 1 us before the generator sees it
  always_ff @(posedge clk_sys or negedge frst_n) begin
    if (!frst_n) begin
      shift_req_ff <= 1'b0;
    end else if (q3_rise) begin
      shift_req_ff <= ctrl.shift_cmd;
    end
  end

  always_ff @(posedge clk_sys or negedge frst_n) begin
    if (!frst_n) begin
      shift_cnt_ff <= '0;
      shift_out_ff <= 1'b0;
    end else if (shift_req_ff == shift_out_ff) begin
      shift_cnt_ff <= '0;
    end else if (shift_cnt_ff == ($bits(shift_cnt_ff))'(SHIFT_DLY_CYC - 1)) begin
      shift_cnt_ff <= '0;
      shift_out_ff <= shift_req_ff;
    end else begin
      shift_cnt_ff <= shift_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      check_gen_shift <= 1'b0;
      frst_prev_ff <= 1'b0;
    end else begin
      check_gen_shift <= shift_out_ff;
      frst_prev_ff <= frst_n;
    end
  end

  property p_hit_sets;
    @(posedge clk_sys) disable iff (!frst_n)
    (!ctrl.write_mode && ref_rise && pattern_hit_pulse) |=> hit_ff;
  endproperty
  a_hit_sets: assert property (p_hit_sets) else $error("hit latch not set");

  property p_rate_read_switch;
    @(posedge clk_sys) disable iff (!frst_n)
    (!ctrl.write_mode && hit_ff && q3_rise && !ctrl.formatter_reset) |=> !rate_fast_ff;
  endproperty
  a_rate_read_switch: assert property (p_rate_read_switch) else $error("rate not slowed");

  property p_rate_stays_slow;
    @(posedge clk_sys) disable iff (!frst_n)
    (!ctrl.write_mode && !rate_fast_ff) |=> !rate_fast_ff;
  endproperty
  a_rate_stays_slow: assert property (p_rate_stays_slow) else $error("read rate restored");

  property p_reset_state;
    @(posedge clk_sys) disable iff (!rst_sync_ff)
    (frst_prev_ff && !frst_n) |-> (rate_fast_ff && !hit_ff);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_rx_clk_slow;
    @(posedge clk_sys) disable iff (!frst_n)
    (!rate_fast_ff) |=> (adapter_rx_clk == $past(cnt_ff[0]));
  endproperty
  a_rx_clk_slow: assert property (p_rx_clk_slow) else $error("rx clock not bit0");

  property p_crc_en_write;
    @(posedge clk_sys) disable iff (!frst_n)
    (ctrl.write_mode && q3_rise && tx_underflow) |=> !crc_en_ff;
  endproperty
  a_crc_en_write: assert property (p_crc_en_write) else $error("enable despite underflow");

  property p_underflow_clears;
    @(posedge clk_sys) disable iff (!frst_n)
    (ctrl.write_mode && tx_underflow && rate_fast_ff) |=> (cnt_ff == 4'h0);
  endproperty
  a_underflow_clears: assert property (p_underflow_clears) else $error("counter kept");

  property p_check_clear;
    @(posedge clk_sys) disable iff (!frst_n)
    (hit_ff && q3n_rise && !check_all_zero_n) |=> !check_ff ##2 !check_result;
  endproperty
  a_check_clear: assert property (p_check_clear) else $error("check latch not cleared");

  property p_shift_delay;
    @(posedge clk_sys) disable iff (!frst_n)
    $rose(shift_req_ff) |-> !shift_out_ff [*3];
  endproperty
  a_shift_delay: assert property (p_shift_delay) else $error("shift passed early");
endmodule // dtfs_sequencer

/* dv/dtfs_adapter_model.sv */
// far side of the sequencer: serial adapter outputs, check flag, recovered clock
// assumes clk_sys at 100 MHz; the recovered reference runs free at 500 kHz
`timescale 1ns/1ps
module dtfs_adapter_model (
  input wire logic clk_sys,
  input wire logic arm_hit,
  input wire logic start_gap,
  input wire logic zero_ok,
  output logic ref_clk,
  output logic read_data,
  output logic pattern_hit_pulse,
  output logic tx_underflow,
  output logic check_all_zero_n
);
  import dtfs_pkg::*;
  logic [7:0] div_ff = 8'h00;
  logic [15:0] mark_ff = {SYNC_PATTERN, ID_MARK_TAIL};
  logic [2:0] bit_ff = 3'h0;
  logic [3:0] uf_ff = 4'h0;
  logic armed_ff = 1'b0;
  logic rise;
  assign rise = (div_ff == 8'h63);
  assign ref_clk = (div_ff >= 8'h64);
  initial begin
    read_data = 1'b0;
    pattern_hit_pulse = 1'b0;
    tx_underflow = 1'b0;
    check_all_zero_n = 1'b1;
  end
  always @(posedge clk_sys) begin
    div_ff <= (div_ff == 8'hC7) ? 8'h00 : div_ff + 8'h01;
    check_all_zero_n <= ~zero_ok;
    if (rise) begin
      mark_ff <= {mark_ff[14:0], mark_ff[15]};
      read_data <= mark_ff[15];
      // one read clock period per arming
      pattern_hit_pulse <= arm_hit && !armed_ff;
      armed_ff <= arm_hit;
      bit_ff <= start_gap ? bit_ff + 3'h1 : 3'h0;
      // idle transmitter keeps underflowing; a gap gives eleven, then the mark leaves none
      tx_underflow <= !start_gap || ((bit_ff == 3'h0) && (uf_ff < 4'hB));
      if (!start_gap) begin
        uf_ff <= 4'h0;
      end else if (bit_ff == 3'h0 && uf_ff < 4'hB) begin
        uf_ff <= uf_ff + 4'h1;
      end
    end
  end
endmodule // dtfs_adapter_model

/* dv/test_disk_track_formatter_sequencer.sv */
// self-checking bench: register accesses, read sync, check latch, write sequencing
// assumes the adapter model drives all link inputs of the sequencer
`timescale 1ns/1ps
module test_disk_track_formatter_sequencer;
  import dtfs_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic ref_clk, read_data, pattern_hit_pulse, tx_underflow, check_all_zero_n;
  logic adapter_rx_clk, adapter_tx_clk, check_gen_clk, check_gen_data;
  logic check_gen_enable, check_gen_preset, check_gen_shift, check_result;
  logic arm_hit = 1'b0, start_gap = 1'b0, zero_ok = 1'b0;
  int n_fail = 0;
  int tests_run = 0;
  int n;
  always #5 clk_sys = ~clk_sys;

  dtfs_sequencer #(.SHIFT_DLY_CYC(4)) i_dtfs_sequencer (.clk_sys(clk_sys), .reset_n(reset_n),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .ref_clk(ref_clk), .read_data(read_data),
    .pattern_hit_pulse(pattern_hit_pulse), .tx_underflow(tx_underflow),
    .check_all_zero_n(check_all_zero_n), .adapter_rx_clk(adapter_rx_clk),
    .adapter_tx_clk(adapter_tx_clk), .check_gen_clk(check_gen_clk),
    .check_gen_data(check_gen_data), .check_gen_enable(check_gen_enable),
    .check_gen_preset(check_gen_preset), .check_gen_shift(check_gen_shift),
    .check_result(check_result));

  dtfs_adapter_model i_dtfs_adapter_model (.clk_sys(clk_sys), .arm_hit(arm_hit),
    .start_gap(start_gap), .zero_ok(zero_ok), .ref_clk(ref_clk), .read_data(read_data),
    .pattern_hit_pulse(pattern_hit_pulse), .tx_underflow(tx_underflow),
    .check_all_zero_n(check_all_zero_n));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang(input int k, input int lim);
    if (k >= lim) begin
      n_fail++;
      $display("[ERR] t=%0t waited=%h limit=%h", $time, k, lim);
      print_verdict();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
      k++;
    end while (s_bvalid !== 1'b1 && k < 100);
    r = s_bresp;
    hang(k, 100);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
      k++;
    end while (s_rvalid !== 1'b1 && k < 100);
    d = s_rdata;
    r = s_rresp;
    hang(k, 100);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, ed);
    chk(32'(r), 32'(er));
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk(32'(r), 32'(er));
  endtask

  task automatic wait_for(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    hang(k, lim);
  endtask

  // cycles from a rise of s to its next fall
  task automatic high_width(ref logic s, output int k);
    wait_for(s, 1'b0, 500, k);
    wait_for(s, 1'b1, 500, k);
    wait_for(s, 1'b0, 500, k);
  endtask

  task automatic frst();
    wr_chk(CTRL_OFS, 32'h1, 2'b00);
    repeat (3) @(posedge clk_sys);
    chk(32'(check_gen_preset), 32'h1);
    wr_chk(CTRL_OFS, 32'h0, 2'b00);
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    chk(32'(check_result), 32'h1);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    frst();
    rd_chk(STAT_OFS, 32'h5, 2'b00);
    rd_chk(8'h08, 32'h0, 2'b10);
    wr_chk(8'h0C, 32'h1, 2'b10);
    high_width(adapter_rx_clk, n);
    chk(32'(n), 32'd100);
    $display("registers and reset done");

    arm_hit <= 1'b1;
    wait_for(check_gen_enable, 1'b1, 500, n);
    rd_chk(STAT_OFS, 32'h07, 2'b00);
    repeat (2000) @(posedge clk_sys);
    high_width(adapter_rx_clk, n);
    chk(32'(n), 32'd200);
    chk(32'(check_gen_clk), 32'(!adapter_rx_clk));
    repeat (3000) @(posedge clk_sys);
    rd_chk(STAT_OFS, 32'h03, 2'b00);
    zero_ok <= 1'b1;
    wait_for(check_result, 1'b0, 3400, n);
    zero_ok <= 1'b0;
    rd_chk(STAT_OFS, 32'h02, 2'b00);
    wait_for(check_result, 1'b1, 3400, n);
    chk(32'(n >= 3150 && n <= 3210), 32'h1);
    arm_hit <= 1'b0;
    frst();
    rd_chk(STAT_OFS, 32'h5, 2'b00);
    high_width(adapter_rx_clk, n);
    chk(32'(n), 32'd100);
    $display("read sequence done");

    wr_chk(CTRL_OFS, 32'h3, 2'b00);
    wr_chk(CTRL_OFS, 32'h2, 2'b00);
    start_gap <= 1'b1;
    for (int i = 0; i < GAP_UNDERFLOWS; i++) begin
      wait_for(tx_underflow, 1'b1, 1700, n);
      chk(32'(check_gen_enable), 32'h0);
      wait_for(tx_underflow, 1'b0, 500, n);
    end
    wait_for(check_gen_enable, 1'b1, 3400, n);
    repeat (3400) @(posedge clk_sys);
    high_width(adapter_tx_clk, n);
    chk(32'(n), 32'd200);
    wr_chk(CTRL_OFS, 32'h6, 2'b00);
    wait_for(check_gen_shift, 1'b1, 3500, n);
    wr_chk(CTRL_OFS, 32'h2, 2'b00);
    wait_for(check_gen_shift, 1'b0, 3500, n);
    start_gap <= 1'b0;
    wait_for(check_gen_enable, 1'b0, 3500, n);
    repeat (3300) @(posedge clk_sys);
    rd_chk(STAT_OFS, 32'h5, 2'b00);
    high_width(adapter_tx_clk, n);
    chk(32'(n), 32'd100);
    $display("write sequence done");
    print_verdict();
  end
endmodule // test_disk_track_formatter_sequencer
